// [blrc_pkg.sv]
//------------------------------------------------------------------
// backlight and regulator control register constants
//------------------------------------------------------------------
package blrc_pkg;

  //------------------------------------------------------------------
  // write port layout and field sizes
  //------------------------------------------------------------------
  localparam int ADDR_W = 5;      // up to 32 registers
  localparam int DATA_W = 6;      // six bits per register
  localparam int SINKS = 6;       // number of current sinks
  localparam int CUR_W = 6;       // current in half milliamps, 0..50
  localparam int DV_W = 6;        // voltage in 100 mV units, 0..33

  //------------------------------------------------------------------
  // register offsets
  //------------------------------------------------------------------
  localparam logic [4:0] SINK_ENABLE_MASK_OFS = 5'h00;
  localparam logic [4:0] MAIN_GROUP_CURRENT_OFS = 5'h01;
  localparam logic [4:0] SUB_GROUP_CURRENT_OFS = 5'h02;
  localparam logic [4:0] REGULATOR1_VOLTAGE_OFS = 5'h05;
  localparam logic [4:0] REGULATOR2_VOLTAGE_OFS = 5'h06;
  localparam logic [4:0] REGULATOR3_VOLTAGE_OFS = 5'h07;
  localparam logic [4:0] BANK_SPLIT_OFS = 5'h0A;

  //------------------------------------------------------------------
  // reset values
  //------------------------------------------------------------------
  localparam logic [5:0] SINK_EN_RST = 6'h00;
  localparam logic [4:0] CUR_CODE_RST = 5'h00;
  localparam logic [3:0] REG4_CODE_RST = 4'h0;
  localparam logic [2:0] REG3B_CODE_RST = 3'h0;
  localparam logic [2:0] SPLIT_RST = 3'h0;

  //------------------------------------------------------------------
  // decode anchors
  //------------------------------------------------------------------
  localparam logic [4:0] CUR_FIRST_HALF = 5'h04;  // 0.5 mA code
  localparam logic [4:0] CUR_FIRST_WHOLE = 5'h0E; // 6 mA code
  localparam logic [4:0] CUR_23MA = 5'h1E;
  localparam logic [5:0] HALF_23MA = 6'h2E;       // 46 half mA
  localparam logic [5:0] HALF_25MA = 6'h32;       // 50 half mA
  localparam logic [2:0] SPLIT_ALL_MAIN = 3'h6;   // codes 6,7 all main

  // data from the pulse decoder: one strobe with address and word
  typedef struct packed {
    logic stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } blrc_wr_t;

  // regulator state: on flag and voltage in 100 mV steps
  typedef struct packed {
    logic on;
    logic [DV_W-1:0] dv;
  } blrc_ldo_t;

  // regulator 1 and 3 ladder, code to 100 mV units
  function automatic logic [DV_W-1:0] blrc_ladder4(input logic [3:0] code);
    logic [DV_W-1:0] v;
    v = 6'h00;
    if (code == 4'h0) v = 6'h00;
    else if (code <= 4'h7) v = 6'(6'h22 - {2'h0, code});
    else if (code <= 4'hA) v = 6'(6'h22 - {2'h0, code});
    else if (code == 4'hB) v = 6'h16;
    else v = 6'(6'h1E - {2'h0, code});
    return v;
  endfunction : blrc_ladder4

endpackage : blrc_pkg

// [blrc_cur_decode.sv]
`timescale 1ns/1ns
//------------------------------------------------------------------
// current code to half milliamp decoder
//------------------------------------------------------------------
module blrc_cur_decode (
  input wire logic [4:0] i_code,    // 5-bit current code
  output logic [5:0] o_half_ma      // current in 0.5 mA units
);

  // ladder: off, reserved, half steps, whole steps, two top steps
  always_comb begin
    if (i_code < blrc_pkg::CUR_FIRST_HALF) begin
      // reserved codes drive no current, same as the off code
      o_half_ma = 6'h00;
    end else if (i_code < blrc_pkg::CUR_FIRST_WHOLE) begin
      o_half_ma = 6'({1'b0, i_code} - 6'h03);
    end else if (i_code < blrc_pkg::CUR_23MA) begin
      o_half_ma = 6'({i_code, 1'b0} - 6'h10);
    end else if (i_code == blrc_pkg::CUR_23MA) begin
      o_half_ma = blrc_pkg::HALF_23MA;
    end else begin
      o_half_ma = blrc_pkg::HALF_25MA;
    end
  end

endmodule : blrc_cur_decode

// [blrc_regs.sv]
`timescale 1ns/1ns
//------------------------------------------------------------------
// backlight and regulator control register bank
//------------------------------------------------------------------
// the bank is fed by the pulse-wire decoder, which hands over one
// address and data word per completed write. there is no read port:
// software cannot see any of this state, only the analog outputs
// that it steers.
module blrc_regs (
  input wire logic i_clk,                       // 100 MHz clock
  input wire logic i_rst_b,                     // sync reset, low
  input wire blrc_pkg::blrc_wr_t i_wr,          // latched write
  output logic [5:0] o_sink_on,                 // sink conducting
  output logic [5:0] o_main_sel,                // sink in main group
  output logic [5:0][5:0] o_sink_half_ma,       // per-sink current
  output logic [5:0] o_main_half_ma,            // main group level
  output logic [5:0] o_sub_half_ma,             // sub group level
  output logic o_backlight_active,              // any sink on
  output blrc_pkg::blrc_ldo_t o_ldo1,           // regulator 1
  output blrc_pkg::blrc_ldo_t o_ldo2,           // regulator 2
  output blrc_pkg::blrc_ldo_t o_ldo3            // regulator 3
);

  //------------------------------------------------------------------
  // state
  //------------------------------------------------------------------
  // every flip-flop of the bank lives in this one struct; the
  // decoded outputs are held here too so that they come from flops
  typedef struct packed {
    logic [5:0] sink_enable_bits;   // stored enable mask
    logic [4:0] main_current_code;  // stored main code
    logic [4:0] sub_current_code;   // stored sub code
    logic [3:0] regulator1_code;    // stored regulator 1 code
    logic [2:0] regulator2_code;    // stored regulator 2 code
    logic [3:0] regulator3_code;    // stored regulator 3 code
    logic [2:0] bank_split_code;    // stored main group split
    logic [5:0] main_sel;           // decoded main membership
    logic [5:0] sink_on;            // decoded sink activity
    logic [5:0][5:0] sink_half_ma;  // decoded per-sink current
    logic [5:0] main_half_ma;       // decoded main level
    logic [5:0] sub_half_ma;        // decoded sub level
    blrc_pkg::blrc_ldo_t ldo1;      // decoded regulator 1
    blrc_pkg::blrc_ldo_t ldo2;      // decoded regulator 2
    blrc_pkg::blrc_ldo_t ldo3;      // decoded regulator 3
  } blrc_state_t;

  blrc_state_t state_reg;   // registered state
  blrc_state_t state_next;  // next state

  //------------------------------------------------------------------
  // decode helpers
  //------------------------------------------------------------------
  logic [5:0] main_dec;  // main code after the ladder
  logic [5:0] sub_dec;   // sub code after the ladder
  logic [4:0] main_code_in;  // main code as the coming edge stores it
  logic [4:0] sub_code_in;   // sub code as the coming edge stores it

  // true when this cycle carries a write to the given offset
  function automatic logic wr_hits(
    input blrc_pkg::blrc_wr_t wr,
    input logic [4:0] ofs
  );
    return wr.stb && (wr.addr == ofs);
  endfunction : wr_hits

  // split code to main membership mask, sink 0 first
  function automatic logic [5:0] split_mask(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h3F;
    // codes past the last split leave every sink in the main group
    if (code < blrc_pkg::SPLIT_ALL_MAIN) begin
      m = 6'(6'h3F >> code);
    end
    return m;
  endfunction : split_mask

  // regulator 2 code: off, then 1.8 V down to 1.2 V
  function automatic blrc_pkg::blrc_ldo_t ldo2_decode(
    input logic [2:0] code
  );
    blrc_pkg::blrc_ldo_t r;
    r.on = (code != 3'h0);
    r.dv = r.on ? 6'(6'h13 - {3'h0, code}) : 6'h00;
    return r;
  endfunction : ldo2_decode

  // regulator 1 and 3 share one ladder, zero code means off
  function automatic blrc_pkg::blrc_ldo_t ldo4_decode(
    input logic [3:0] code
  );
    blrc_pkg::blrc_ldo_t r;
    r.on = (code != 4'h0);
    r.dv = blrc_pkg::blrc_ladder4(code);
    return r;
  endfunction : ldo4_decode

  //------------------------------------------------------------------
  // current ladders
  //------------------------------------------------------------------
  // decoders look at the next codes so that a write shows on the
  // outputs at the very edge that stores it; the codes are picked
  // from the write port and the stored copy, not from state_next,
  // so that the decoders do not close a loop through the process
  assign main_code_in = wr_hits(i_wr, blrc_pkg::MAIN_GROUP_CURRENT_OFS) ?
    i_wr.data[4:0] : state_reg.main_current_code;
  assign sub_code_in = wr_hits(i_wr, blrc_pkg::SUB_GROUP_CURRENT_OFS) ?
    i_wr.data[4:0] : state_reg.sub_current_code;

  blrc_cur_decode u_main_dec (
    .i_code(main_code_in),
    .o_half_ma(main_dec)
  );

  // the sub group uses the identical ladder
  blrc_cur_decode u_sub_dec (
    .i_code(sub_code_in),
    .o_half_ma(sub_dec)
  );

  //------------------------------------------------------------------
  // next state
  //------------------------------------------------------------------
  // register writes first, then every decoded field from the new
  // register contents
  always_comb begin
    state_next = state_reg;

    // register writes; unmapped addresses are dropped silently
    if (i_wr.stb) begin
      unique case (i_wr.addr)
        blrc_pkg::SINK_ENABLE_MASK_OFS: begin
          state_next.sink_enable_bits = i_wr.data;
        end
        blrc_pkg::MAIN_GROUP_CURRENT_OFS: begin
          // bit 5 is not kept, whatever the host sends
          state_next.main_current_code = i_wr.data[4:0];
        end
        blrc_pkg::SUB_GROUP_CURRENT_OFS: begin
          state_next.sub_current_code = i_wr.data[4:0];
        end
        blrc_pkg::REGULATOR1_VOLTAGE_OFS: begin
          // bits 5 and 4 are not kept
          state_next.regulator1_code = i_wr.data[3:0];
        end
        blrc_pkg::REGULATOR2_VOLTAGE_OFS: begin
          // bits 5 to 3 are not kept
          state_next.regulator2_code = i_wr.data[2:0];
        end
        blrc_pkg::REGULATOR3_VOLTAGE_OFS: begin
          state_next.regulator3_code = i_wr.data[3:0];
        end
        blrc_pkg::BANK_SPLIT_OFS: begin
          // upper bits are not kept, so a stray one cannot move sinks
          state_next.bank_split_code = i_wr.data[2:0];
        end
        default: begin
          // other addresses hold nothing in this bank
          state_next.sink_enable_bits = state_reg.sink_enable_bits;
        end
      endcase
    end

    // group levels follow the codes with no fade delay
    state_next.main_half_ma = main_dec;
    state_next.sub_half_ma = sub_dec;

    // membership: sinks beyond the main split fall to the sub group
    state_next.main_sel = split_mask(state_next.bank_split_code);

    // per-sink current: one shared level per group
    for (int i = 0; i < blrc_pkg::SINKS; i++) begin
      if (!state_next.sink_enable_bits[i]) begin
        // a cleared enable stops the sink whatever its group level
        state_next.sink_half_ma[i] = 6'h00;
      end else if (state_next.main_sel[i]) begin
        state_next.sink_half_ma[i] = main_dec;
      end else begin
        state_next.sink_half_ma[i] = sub_dec;
      end
      // the zero code also stops the sink although it stays enabled
      state_next.sink_on[i] = (state_next.sink_half_ma[i] != 6'h00);
    end

    // regulators: code selects the level and zero switches off
    state_next.ldo1 = ldo4_decode(state_next.regulator1_code);
    state_next.ldo2 = ldo2_decode(state_next.regulator2_code);
    state_next.ldo3 = ldo4_decode(state_next.regulator3_code);
  end

  //------------------------------------------------------------------
  // state register
  //------------------------------------------------------------------
  // all registers but main_sel come back at zero: sinks off, regulators off,
  // every sink in the main group
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_reg.sink_enable_bits <= blrc_pkg::SINK_EN_RST;
      state_reg.main_current_code <= blrc_pkg::CUR_CODE_RST;
      state_reg.sub_current_code <= blrc_pkg::CUR_CODE_RST;
      state_reg.regulator1_code <= blrc_pkg::REG4_CODE_RST;
      state_reg.regulator2_code <= blrc_pkg::REG3B_CODE_RST;
      state_reg.regulator3_code <= blrc_pkg::REG4_CODE_RST;
      state_reg.bank_split_code <= blrc_pkg::SPLIT_RST;
      state_reg.main_sel <= 6'h3F;
      state_reg.sink_on <= 6'h00;
      state_reg.sink_half_ma <= '0;
      state_reg.main_half_ma <= 6'h00;
      state_reg.sub_half_ma <= 6'h00;
      state_reg.ldo1 <= '0;
      state_reg.ldo2 <= '0;
      state_reg.ldo3 <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  //------------------------------------------------------------------
  // outputs
  //------------------------------------------------------------------
  // every output but o_backlight_active is a flop; none of them feeds back to the host,
  // since the bank has no read path at all
  assign o_sink_on = state_reg.sink_on;
  assign o_main_sel = state_reg.main_sel;
  assign o_sink_half_ma = state_reg.sink_half_ma;
  assign o_main_half_ma = state_reg.main_half_ma;
  assign o_sub_half_ma = state_reg.sub_half_ma;
  // low here lets the charge pump drop into its sleep mode
  assign o_backlight_active = |state_reg.sink_on;
  assign o_ldo1 = state_reg.ldo1;
  assign o_ldo2 = state_reg.ldo2;
  assign o_ldo3 = state_reg.ldo3;

endmodule : blrc_regs

// [blrc_regs_asserts.sv]
`timescale 1ns/1ns
// ------------------------------
// checker for the control bank
// ------------------------------
module blrc_regs_asserts (
  input wire logic i_clk,                      // clock
  input wire logic i_rst_b,                    // sync reset, low
  input wire blrc_pkg::blrc_wr_t i_wr,         // latched write
  input wire logic [5:0] o_sink_on,            // sink conducting
  input wire logic [5:0] o_main_sel,           // sink in main group
  input wire logic [5:0][5:0] o_sink_half_ma,  // per-sink current
  input wire logic [5:0] o_main_half_ma,       // main level
  input wire logic [5:0] o_sub_half_ma,        // sub level
  input wire logic o_backlight_active,         // any sink on
  input wire blrc_pkg::blrc_ldo_t o_ldo1,      // regulator 1
  input wire blrc_pkg::blrc_ldo_t o_ldo2,      // regulator 2
  input wire blrc_pkg::blrc_ldo_t o_ldo3       // regulator 3
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // own decoders, so a shared slip cannot hide itself
  function automatic logic [5:0] half(input logic [4:0] c);
    if (c < 5'h04) return 6'h00;
    if (c < 5'h0E) return 6'(c - 5'h03);
    if (c < 5'h1E) return 6'({c, 1'b0} - 6'h10);
    return (c == 5'h1E) ? 6'h2E : 6'h32;
  endfunction : half
  function automatic logic [6:0] lad(input logic [3:0] c);
    if (c == 4'h0) return 7'h00;
    if (c < 4'hB) return {1'b1, 6'(6'h22 - c)};
    return (c == 4'hB) ? 7'h56 : {1'b1, 6'(6'h1E - c)};
  endfunction : lad
  // one taken write to a given offset
  sequence s_wr(logic [4:0] a);
    i_wr.stb && i_wr.addr == a;
  endsequence
  a_main_code: assert property (
    s_wr(5'h01) |=> o_main_half_ma == half($past(i_wr.data[4:0])))
    else $error("main level wrong");
  a_sub_code: assert property (
    s_wr(5'h02) |=> o_sub_half_ma == half($past(i_wr.data[4:0])))
    else $error("sub level wrong");
  a_reg1_code: assert property (
    s_wr(5'h05) |=> o_ldo1 == lad($past(i_wr.data[3:0])))
    else $error("regulator 1 wrong");
  a_reg2_code: assert property (
    s_wr(5'h06) |=> o_ldo2.on == ($past(i_wr.data[2:0]) != 3'h0)
      && o_ldo2.dv == (($past(i_wr.data[2:0]) != 3'h0) ?
      6'(6'h13 - $past(i_wr.data[2:0])) : 6'h00))
    else $error("regulator 2 wrong");
  a_reg3_code: assert property (
    s_wr(5'h07) |=> o_ldo3 == lad($past(i_wr.data[3:0])))
    else $error("regulator 3 wrong");
  a_active_or: assert property (o_backlight_active == |o_sink_on)
    else $error("active flag wrong");
  // writes elsewhere or no write leave the regulators and the per-sink currents alone
  a_idle_hold: assert property (
    !(i_wr.stb && i_wr.addr inside {5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0A})
      |=> $stable(o_ldo1) && $stable(o_ldo2) && $stable(o_ldo3) && $stable(o_sink_half_ma))
    else $error("setting moved without write");
  for (genvar g = 0; g < 6; g++) begin : g_sink
    a_main_share: assert property (
      o_sink_on[g] && o_main_sel[g] |-> o_sink_half_ma[g] == o_main_half_ma)
      else $error("main sink level wrong");
    a_sub_join: assert property (
      o_sink_on[g] && !o_main_sel[g] |-> o_sink_half_ma[g] == o_sub_half_ma)
      else $error("sub sink level wrong");
    a_off_zero: assert property (!o_sink_on[g] |-> o_sink_half_ma[g] == 6'h00)
      else $error("off sink draws current");
  end
endmodule : blrc_regs_asserts
bind blrc_regs blrc_regs_asserts u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr(i_wr),
  .o_sink_on(o_sink_on), .o_main_sel(o_main_sel), .o_sink_half_ma(o_sink_half_ma),
  .o_main_half_ma(o_main_half_ma), .o_sub_half_ma(o_sub_half_ma),
  .o_backlight_active(o_backlight_active), .o_ldo1(o_ldo1), .o_ldo2(o_ldo2),
  .o_ldo3(o_ldo3));

// [blrc_host_model.sv]
`timescale 1ns/1ns
// ------------------------------
// host side: one strobe per write, no read path
// ------------------------------
module blrc_host_model (
  input wire logic i_clk,              // clock
  input wire logic i_req,              // write wanted
  input wire logic [4:0] i_addr,       // target offset
  input wire logic [5:0] i_data,       // raw word
  input wire logic i_dirty,            // leave unused bits set
  output blrc_pkg::blrc_wr_t o_wr      // write to the bank
);
  logic [10:0] junk_reg = 11'h155; // churns while idle, never a stale word
  always @(posedge i_clk) junk_reg <= junk_reg + 11'h2A5;
  // unused bits cleared unless a test wants them dirty
  function automatic logic [5:0] keep(input logic [4:0] a);
    case (a)
      5'h01, 5'h02: return 6'h1F;
      5'h05, 5'h07: return 6'h0F;
      5'h06, 5'h0A: return 6'h07;
      default: return 6'h3F;
    endcase
  endfunction : keep
  // write only: nothing is ever read back
  always_comb o_wr = i_req ? {1'b1, i_addr, i_data & (i_dirty ? 6'h3F : keep(i_addr))}
    : {1'b0, junk_reg};
endmodule : blrc_host_model

// [backlight_regulator_control_regs_test.sv]
`timescale 1ns/1ns
module backlight_regulator_control_regs_test;
  logic i_clk, i_rst_b, req, dirty, act;
  logic [4:0] addr, mc, sc;
  logic [5:0] data, sink_on, main_sel, main_ma, sub_ma, en;
  logic [5:0][5:0] sink_ma;
  logic [3:0] c1, c3;
  logic [2:0] c2, sp;
  logic [31:0] r;
  logic [4:0] tbl [8] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0A, 5'h03};
  blrc_pkg::blrc_wr_t wr;
  blrc_pkg::blrc_ldo_t l1, l2, l3;
  int num_errors, n_compared, seed, cyc;
  blrc_host_model u_host (.i_clk(i_clk), .i_req(req), .i_addr(addr), .i_data(data),
    .i_dirty(dirty), .o_wr(wr));
  blrc_regs dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr(wr), .o_sink_on(sink_on),
    .o_main_sel(main_sel), .o_sink_half_ma(sink_ma), .o_main_half_ma(main_ma),
    .o_sub_half_ma(sub_ma), .o_backlight_active(act), .o_ldo1(l1), .o_ldo2(l2),
    .o_ldo3(l3));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // expected decodes, in 0.5 mA and 100 mV units
  function automatic logic [5:0] half(input logic [4:0] c);
    if (c < 5'h04) return 6'h00;
    if (c < 5'h0E) return 6'(c - 5'h03);
    if (c < 5'h1E) return 6'({c, 1'b0} - 6'h10);
    return (c == 5'h1E) ? 6'h2E : 6'h32;
  endfunction : half
  function automatic logic [6:0] ldo(input logic [3:0] c, input logic two);
    if (c == 4'h0) return 7'h00;
    if (two) return {1'b1, 6'(6'h13 - c)};
    if (c < 4'hB) return {1'b1, 6'(6'h22 - c)};
    return (c == 4'hB) ? {1'b1, 6'h16} : {1'b1, 6'(6'h1E - c)};
  endfunction : ldo
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmp
  // one write per cycle; the expectation follows the mapped offsets
  task automatic wr_reg(input logic [4:0] a, input logic [5:0] d, input logic x);
    @(negedge i_clk);
    req = 1'b1;
    addr = a;
    data = d;
    dirty = x;
    case (a)
      5'h00: en = d;
      5'h01: mc = d[4:0];
      5'h02: sc = d[4:0];
      5'h05: c1 = d[3:0];
      5'h06: c2 = d[2:0];
      5'h07: c3 = d[3:0];
      5'h0A: sp = d[2:0];
      default: ;
    endcase
  endtask : wr_reg
  task automatic idle();
    @(negedge i_clk);
    req = 1'b0;
  endtask : idle
  task automatic check();
    logic [5:0] sel, lv, on;
    sel = (sp >= 3'h6) ? 6'h3F : 6'h3F >> sp;
    on = 6'h00;
    cmp(main_sel, sel);
    cmp(main_ma, half(mc));
    cmp(sub_ma, half(sc));
    for (int i = 0; i < 6; i++) begin
      lv = sel[i] ? half(mc) : half(sc);
      on[i] = en[i] && lv != 6'h00;
      cmp(sink_ma[i], en[i] ? lv : 6'h00);
      cmp(sink_on[i], on[i]);
    end
    cmp(act, |on);
    cmp(l1, ldo(c1, 1'b0));
    cmp(l2, ldo({1'b0, c2}, 1'b1));
    cmp(l3, ldo(c3, 1'b0));
  endtask : check
  task automatic do_reset();
    @(negedge i_clk);
    i_rst_b = 1'b0;
    repeat (20) @(negedge i_clk);
    i_rst_b = 1'b1;
    {en, mc, sc, c1, c2, c3, sp} = '0;
    check();
    $display("reset test done");
  endtask : do_reset
  // hang guard well above the under 900 cycles used
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    {i_rst_b, req, dirty, addr, data, num_errors, n_compared, cyc} = '0;
    seed = 32'hB7FC;
    do_reset();
    // every regulator code, written back to back
    for (int k = 0; k < 16; k++) begin
      wr_reg(5'h05, 6'(k), 1'b0);
      wr_reg(5'h06, 6'(k), 1'b0);
      wr_reg(5'h07, 6'(15 - k), 1'b0);
      idle();
      check();
    end
    $display("regulator test done");
    // every current code with unused bits set and each split
    wr_reg(5'h00, 6'h3F, 1'b0);
    for (int k = 0; k < 32; k++) begin
      wr_reg(5'h01, 6'(k + 32), 1'b1);
      wr_reg(5'h02, 6'(63 - k), 1'b1);
      wr_reg(5'h0A, 6'(k % 8 + 56), 1'b1);
      idle();
      check();
    end
    wr_reg(5'h00, 6'h00, 1'b0);
    idle();
    check();
    wr_reg(5'h00, 6'h3F, 1'b0);
    wr_reg(5'h01, 6'h00, 1'b0);
    idle();
    check();
    $display("current test done");
    // unmapped offsets and random traffic
    for (int k = 0; k < 300; k++) begin
      r = $random(seed);
      wr_reg(k < 20 ? 5'(r[12:8] | 5'h10) : tbl[r[2:0]], r[9:4], r[10]);
      if (r[11]) begin
        idle();
        check();
      end
    end
    idle();
    check();
    $display("random test done");
    do_reset();
    summarize();
  end
endmodule : backlight_regulator_control_regs_test
